// ### shared/spx_pkg.sv
package spx_pkg;
  // Configuration offsets, byte addresses of aligned dwords
  localparam logic [11:0] OFS_LINK_STAT2 = 12'h098;
  localparam logic [11:0] OFS_SLOT_CAP2  = 12'h09C;
  localparam logic [11:0] OFS_SLOT_CS2   = 12'h0A0;
  localparam logic [11:0] OFS_SUBSYS_HDR = 12'h0A4;
  localparam logic [11:0] OFS_SUBSYS_ID  = 12'h0A8;
  localparam logic [11:0] OFS_BWIN_CFG   = 12'h0E4;
  localparam logic [11:0] OFS_SER_HDR    = 12'h100;
  localparam logic [11:0] OFS_SER_LOW    = 12'h104;
  localparam logic [11:0] OFS_SER_HIGH   = 12'h108;
  localparam logic [11:0] OFS_PWR_HDR    = 12'h138;
  localparam logic [11:0] OFS_PWR_SEL    = 12'h13C;
  localparam logic [11:0] OFS_PWR_DATA   = 12'h140;
  // Fixed capability fields
  localparam logic [7:0]  SUBSYS_CAP_ID  = 8'h0D;
  localparam logic [7:0]  SUBSYS_NEXT    = 8'h00;
  localparam logic [15:0] SER_CAP_ID     = 16'h0003;
  localparam logic [15:0] PWR_CAP_ID     = 16'h0004;
  localparam logic [3:0]  EXT_CAP_VER    = 4'h1;
  localparam int          DEEMPH_BIT     = 16;
  // Reset values of preloadable and host-writable fields, window type codes
  localparam logic [11:0] SER_NEXT_RST   = 12'hFB4;
  localparam logic [11:0] PWR_NEXT_RST   = 12'h148;
  localparam logic [31:0] SER_WORD_RST   = 32'h0000_0000;
  localparam logic [1:0]  BWIN_TYPE_RST  = 2'h2;
  localparam logic [1:0]  BWIN_OFF       = 2'h0;
  localparam logic [1:0]  BWIN_32        = 2'h2;
  localparam logic [1:0]  BWIN_64        = 2'h3;
  localparam logic [2:0]  BWIN_RST       = 3'h2;
  localparam logic [7:0]  PWR_SEL_RST    = 8'h00;
  // Arbitrary neutral identity values
  localparam logic [15:0] SUBSYS_MAKER_RST  = 16'h1A2B;
  localparam logic [15:0] SUBSYS_DEVICE_RST = 16'h3C4D;
  // Power budget data entries
  localparam logic [7:0]  PWR_SEL_MAX    = 8'h00;
  localparam logic [7:0]  PWR_SEL_SUST   = 8'h01;
  localparam logic [7:0]  PWR_BASE_MAX   = 8'h04;
  localparam logic [7:0]  PWR_BASE_SUST  = 8'h03;
  localparam logic [2:0]  PWR_TYPE_MAX   = 3'h7;
  localparam logic [2:0]  PWR_TYPE_SUST  = 3'h3;
  localparam logic [2:0]  PWR_RAIL       = 3'h2;
  // Field positions inside the power budget data word
  localparam int          PWR_TYPE_LSB   = 15;
  localparam int          PWR_RAIL_LSB   = 18;
endpackage

// ### shared/spx_pre_if.sv
`timescale 1ns/1ps
interface spx_pre_if;
  logic [15:0] maker_code;   // Subsystem maker code
  logic [15:0] device_code;  // Subsystem device code
  logic [31:0] ser_low;      // Serial number, first dword
  logic [31:0] ser_high;     // Serial number, second dword
  logic [11:0] ser_next;     // Serial header next pointer
  logic [11:0] pwr_next;     // Power header next pointer
  logic [2:0]  bwin_def;     // Base window default
  logic        ready;        // Loader finished
  modport src (output maker_code, device_code, ser_low, ser_high, ser_next, pwr_next,
               bwin_def, ready);
  modport dst (input maker_code, device_code, ser_low, ser_high, ser_next, pwr_next,
               bwin_def, ready);
endinterface

// ### rtl/spx_sync.sv
`timescale 1ns/1ps
module spx_sync (
  input  wire logic i_mclk,
  input  wire logic i_reset,
  input  wire logic i_pin,
  output logic      o_level,
  output logic      o_valid
);
  logic [2:0] sh_r;    // Three stage chain; stage 0 feeds only stage 1
  logic [2:0] fill_r;  // Ones walk in as the chain fills after reset

  // Sample the pin
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      sh_r   <= 3'h0;
      fill_r <= 3'h0;
    end else begin
      sh_r   <= {sh_r[1:0], i_pin};
      fill_r <= {fill_r[1:0], 1'b1};
    end
  end

  // Accept a value once stages 1 and 2 agree
  // Reset zeros are not a sample of the pin, so wait until the chain is full
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_level <= 1'b0;
      o_valid <= 1'b0;
    end else if (fill_r[2] && sh_r[2] == sh_r[1]) begin
      o_level <= sh_r[2];
      o_valid <= 1'b1;
    end
  end
endmodule // spx_sync

// ### rtl/spx_preload.sv
`timescale 1ns/1ps
module spx_preload (
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  input  wire logic        i_ld_we,
  input  wire logic [11:0] i_ld_addr,
  input  wire logic [31:0] i_ld_data,
  input  wire logic        i_ld_done,
  spx_pre_if.src           pre
);
  // Loader writes land here; values are reset defaults until overwritten
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      pre.maker_code  <= spx_pkg::SUBSYS_MAKER_RST;
      pre.device_code <= spx_pkg::SUBSYS_DEVICE_RST;
      pre.ser_low     <= spx_pkg::SER_WORD_RST;
      pre.ser_high    <= spx_pkg::SER_WORD_RST;
      pre.ser_next    <= spx_pkg::SER_NEXT_RST;
      pre.pwr_next    <= spx_pkg::PWR_NEXT_RST;
      pre.bwin_def    <= spx_pkg::BWIN_RST;
    end else if (i_ld_we && !pre.ready) begin
      // Loader addresses the same offsets the host sees
      case (i_ld_addr)
        spx_pkg::OFS_SUBSYS_ID: begin
          pre.maker_code  <= i_ld_data[15:0];
          pre.device_code <= i_ld_data[31:16];
        end
        spx_pkg::OFS_SER_LOW:  pre.ser_low  <= i_ld_data;
        spx_pkg::OFS_SER_HIGH: pre.ser_high <= i_ld_data;
        spx_pkg::OFS_SER_HDR:  pre.ser_next <= i_ld_data[31:20];
        spx_pkg::OFS_PWR_HDR:  pre.pwr_next <= i_ld_data[31:20];
        spx_pkg::OFS_BWIN_CFG: pre.bwin_def <= i_ld_data[2:0];
        default: ;
      endcase
    end
  end

  // Sticky ready; late loader writes are ignored to keep reads stable
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      pre.ready <= 1'b0;
    end else if (i_ld_done) begin
      pre.ready <= 1'b1;
    end
  end
endmodule // spx_preload

// ### rtl/spx_cfg_regs.sv
// Behaviour
// - Bit 16 shows current de-emphasis, port dependent reset
// - Subsystem header low byte reads 0Dh
// - Subsystem next pointer byte reads 00h
// - Subsystem maker code, read-only, preloadable
// - Subsystem device code, read-only, preloadable
// - Window type 00 off, 10 32-bit, 11 64-bit
// - Base window register exists upstream only
// - Serial header identifier reads 0003h
// - Both extended headers report version 1
// - Next pointers FB4h and 148h, preloadable
// - First serial dword read-only, default zero
// - Second serial dword read-only, default zero
// - Power header identifier reads 0004h
// - Power header exists upstream only
// - Selector 00h max, 01h sustained budget
// - Other selector values report zero budget
// - Selector upstream only, writable, resets 00h
// - Base power 04h for 0, 03h for 1
`timescale 1ns/1ps
module spx_cfg_regs (
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  input  wire logic        i_port_up_pin,
  input  wire logic        i_deemph_vld,
  input  wire logic        i_deemph_lvl,
  input  wire logic        i_ld_we,
  input  wire logic [11:0] i_ld_addr,
  input  wire logic [31:0] i_ld_data,
  input  wire logic        i_ld_done,
  input  wire logic        i_cfg_req,
  input  wire logic        i_cfg_we,
  input  wire logic [11:0] i_cfg_addr,
  input  wire logic [3:0]  i_cfg_be,
  input  wire logic [31:0] i_cfg_wdata,
  output logic             o_cfg_ack,
  output logic [31:0]      o_cfg_rdata,
  output logic [1:0]       o_bwin_type,
  output logic             o_bwin_pref,
  output logic             o_ready
);
  spx_pre_if   pre ();       // Preloaded values
  logic        up_lvl;       // Synchronised strap, 1 on upstream port
  logic        up_vld;       // Strap has settled
  logic        strap_done_r; // De-emphasis initialised from strap
  logic        deemph_r;     // Current de-emphasis, 1 means -6.0db
  logic        ready_seen_r; // Preload default copied into the base window register
  logic [2:0]  bwin_r;       // Base window type and prefetch
  logic [7:0]  sel_r;        // Power budget data selector
  logic [11:0] addr_r;       // Offset of the request being answered
  logic        take;         // Request accepted this cycle
  logic [31:0] rd_nxt;       // Read data for the accepted request
  logic [31:0] pwr_data;     // Power budget data word

  // Port role strap arrives from a pin
  spx_sync u_sync (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_pin   (i_port_up_pin),
    .o_level (up_lvl),
    .o_valid (up_vld)
  );

  // Loader front end
  spx_preload u_preload (
    .i_mclk    (i_mclk),
    .i_reset   (i_reset),
    .i_ld_we   (i_ld_we),
    .i_ld_addr (i_ld_addr),
    .i_ld_data (i_ld_data),
    .i_ld_done (i_ld_done),
    .pre       (pre)
  );

  // Hold requests until both loader and strap are settled
  assign take = i_cfg_req && !o_cfg_ack && pre.ready && up_vld && ready_seen_r;

  // De-emphasis: strap picks the reset level, the link updates it later
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      deemph_r     <= 1'b0;
      strap_done_r <= 1'b0;
    end else if (up_vld && !strap_done_r) begin
      deemph_r     <= !up_lvl;
      strap_done_r <= 1'b1;
    end else if (strap_done_r && i_deemph_vld) begin
      deemph_r     <= i_deemph_lvl;
    end
  end

  // Base window register; preload default taken once, host writes after
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      bwin_r       <= spx_pkg::BWIN_RST;
      ready_seen_r <= 1'b0;
    end else if (pre.ready && !ready_seen_r) begin
      bwin_r       <= pre.bwin_def;
      ready_seen_r <= 1'b1;
    end else if (take && i_cfg_we && up_lvl && i_cfg_addr == spx_pkg::OFS_BWIN_CFG
                 && i_cfg_be[0]) begin
      bwin_r       <= i_cfg_wdata[2:0];
    end
  end

  // Selector byte, writable upstream only
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      sel_r <= spx_pkg::PWR_SEL_RST;
    end else if (take && i_cfg_we && up_lvl && i_cfg_addr == spx_pkg::OFS_PWR_SEL
                 && i_cfg_be[0]) begin
      sel_r <= i_cfg_wdata[7:0];
    end
  end

  // Power budget data for the selected entry; unknown entries are zero
  always_comb begin
    pwr_data = 32'h0000_0000;
    if (sel_r == spx_pkg::PWR_SEL_MAX) begin
      pwr_data[7:0]  = spx_pkg::PWR_BASE_MAX;
      pwr_data[spx_pkg::PWR_TYPE_LSB +: 3] = spx_pkg::PWR_TYPE_MAX;
      pwr_data[spx_pkg::PWR_RAIL_LSB +: 3] = spx_pkg::PWR_RAIL;
    end else if (sel_r == spx_pkg::PWR_SEL_SUST) begin
      pwr_data[7:0]  = spx_pkg::PWR_BASE_SUST;
      pwr_data[spx_pkg::PWR_TYPE_LSB +: 3] = spx_pkg::PWR_TYPE_SUST;
      pwr_data[spx_pkg::PWR_RAIL_LSB +: 3] = spx_pkg::PWR_RAIL;
    end
  end

  // Read decode; unmapped and downstream-hidden offsets read zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (i_cfg_addr)
      spx_pkg::OFS_LINK_STAT2: rd_nxt[spx_pkg::DEEMPH_BIT] = deemph_r;
      spx_pkg::OFS_SUBSYS_HDR: rd_nxt = {16'h0000, spx_pkg::SUBSYS_NEXT,
                                         spx_pkg::SUBSYS_CAP_ID};
      spx_pkg::OFS_SUBSYS_ID:  rd_nxt = {pre.device_code, pre.maker_code};
      spx_pkg::OFS_BWIN_CFG: begin
        if (up_lvl) begin
          rd_nxt[2:0] = bwin_r;
        end
      end
      spx_pkg::OFS_SER_HDR:  rd_nxt = {pre.ser_next, spx_pkg::EXT_CAP_VER,
                                       spx_pkg::SER_CAP_ID};
      spx_pkg::OFS_SER_LOW:  rd_nxt = pre.ser_low;
      spx_pkg::OFS_SER_HIGH: rd_nxt = pre.ser_high;
      spx_pkg::OFS_PWR_HDR: begin
        if (up_lvl) begin
          rd_nxt = {pre.pwr_next, spx_pkg::EXT_CAP_VER,
                    spx_pkg::PWR_CAP_ID};
        end
      end
      spx_pkg::OFS_PWR_SEL: begin
        if (up_lvl) begin
          rd_nxt[7:0] = sel_r;
        end
      end
      spx_pkg::OFS_PWR_DATA: begin
        if (up_lvl) begin
          rd_nxt = pwr_data;
        end
      end
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // Answer one cycle after acceptance; writes answer with zero data
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_cfg_ack   <= 1'b0;
      o_cfg_rdata <= 32'h0000_0000;
      addr_r      <= 12'h000;
    end else begin
      o_cfg_ack <= take;
      if (take) begin
        o_cfg_rdata <= i_cfg_we ? 32'h0000_0000 : rd_nxt;
        addr_r      <= i_cfg_addr;
      end
    end
  end

  // Registered copies for the window decoder and ready indication
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_bwin_type <= spx_pkg::BWIN_TYPE_RST;
      o_bwin_pref <= 1'b0;
      o_ready     <= 1'b0;
    end else begin
      o_bwin_type <= up_lvl ? bwin_r[1:0] : spx_pkg::BWIN_OFF;
      o_bwin_pref <= up_lvl && bwin_r[2];
      o_ready     <= pre.ready && up_vld && ready_seen_r;
    end
  end

  // Checks on answered reads, selector writes and answers before preload
  logic rd_ack;  // Read answer this cycle
  logic was_rd_r;  // Answered request was a read
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      was_rd_r <= 1'b0;
    end else if (take) begin
      was_rd_r <= !i_cfg_we;
    end
  end
  assign rd_ack = o_cfg_ack && was_rd_r;

  cap_id_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    rd_ack && addr_r == spx_pkg::OFS_SUBSYS_HDR |-> o_cfg_rdata[7:0] == 8'h0D)
    else $error("subsystem capability id wrong");
  next_ptr_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    rd_ack && addr_r == spx_pkg::OFS_SUBSYS_HDR |-> o_cfg_rdata[31:8] == 24'h000000)
    else $error("subsystem next pointer not zero");
  ser_hdr_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    rd_ack && addr_r == spx_pkg::OFS_SER_HDR |-> o_cfg_rdata[19:0] == 20'h10003)
    else $error("serial header id or version wrong");
  pwr_hdr_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    rd_ack && up_lvl && addr_r == spx_pkg::OFS_PWR_HDR |-> o_cfg_rdata[19:0] == 20'h10004)
    else $error("power header id or version wrong");
  sel_zero_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    rd_ack && addr_r == spx_pkg::OFS_PWR_DATA && sel_r > 8'h01 |-> o_cfg_rdata == 32'h0)
    else $error("unsupported selector gave nonzero budget");
  base_pwr_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    rd_ack && up_lvl && addr_r == spx_pkg::OFS_PWR_DATA && sel_r == 8'h01
      |-> o_cfg_rdata[7:0] == 8'h03)
    else $error("sustained base power wrong");
  down_hide_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    rd_ack && !up_lvl && addr_r == spx_pkg::OFS_BWIN_CFG |-> o_cfg_rdata == 32'h0)
    else $error("window register visible downstream");
  slot_zero_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    rd_ack && (addr_r == spx_pkg::OFS_SLOT_CAP2 || addr_r == spx_pkg::OFS_SLOT_CS2)
      |-> o_cfg_rdata == 32'h0)
    else $error("slot word not zero");
  sel_write_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    take && i_cfg_we && up_lvl && i_cfg_addr == spx_pkg::OFS_PWR_SEL && i_cfg_be[0]
      |=> sel_r == $past(i_cfg_wdata[7:0]) ##1 sel_r == $past(sel_r))
    else $error("selector write not stored");
  hold_ack_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    !pre.ready |=> !o_cfg_ack)
    else $error("answer before preload finished");

  // Link status word: only the de-emphasis bit may be set
  link_upper_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    rd_ack && addr_r == spx_pkg::OFS_LINK_STAT2
      |-> o_cfg_rdata[31:17] == 15'h0 && o_cfg_rdata[15:0] == 16'h0)
    else $error("reserved link status bits not zero");

  // Strap picks the first level: upstream 0, downstream 1
  deemph_init_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    $rose(strap_done_r) |-> deemph_r == !$past(up_lvl))
    else $error("de-emphasis start level wrong");

  // A level reported by the link shows on the next cycle
  deemph_upd_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    strap_done_r && i_deemph_vld |=> deemph_r == $past(i_deemph_lvl))
    else $error("de-emphasis update lost");

  // Downstream ports never open a window in the decoder
  win_down_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    !up_lvl |=> o_bwin_type == spx_pkg::BWIN_OFF && !o_bwin_pref)
    else $error("window decoder enabled downstream");

  // Upstream ports pass type and prefetch flag on unchanged
  win_copy_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    up_lvl |=> {o_bwin_pref, o_bwin_type} == $past(bwin_r))
    else $error("window outputs differ from register");

  // Host write to the window register lands in one cycle
  win_write_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    take && i_cfg_we && up_lvl && i_cfg_addr == spx_pkg::OFS_BWIN_CFG && i_cfg_be[0]
      |=> bwin_r == $past(i_cfg_wdata[2:0]))
    else $error("window write not stored");

  // Power budgeting registers are hidden on downstream ports
  up_only_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    rd_ack && !up_lvl && (addr_r == spx_pkg::OFS_PWR_HDR || addr_r == spx_pkg::OFS_PWR_SEL
      || addr_r == spx_pkg::OFS_PWR_DATA) |-> o_cfg_rdata == 32'h0000_0000)
    else $error("upstream-only register visible downstream");

  // No host access yet, so the selector still holds its reset value
  sel_rst_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    !ready_seen_r |-> sel_r == spx_pkg::PWR_SEL_RST)
    else $error("selector left its reset value");

  // Identity word shows the loaded or default codes
  sub_id_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    rd_ack && addr_r == spx_pkg::OFS_SUBSYS_ID
      |-> o_cfg_rdata == {pre.device_code, pre.maker_code})
    else $error("subsystem codes wrong");

  // Serial number dwords come straight from the loader copy
  ser_low_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    rd_ack && addr_r == spx_pkg::OFS_SER_LOW |-> o_cfg_rdata == pre.ser_low)
    else $error("first serial dword wrong");

  ser_high_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    rd_ack && addr_r == spx_pkg::OFS_SER_HIGH |-> o_cfg_rdata == pre.ser_high)
    else $error("second serial dword wrong");

  // Next pointers follow the loader, version stays fixed
  ser_next_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    rd_ack && addr_r == spx_pkg::OFS_SER_HDR |-> o_cfg_rdata[31:20] == pre.ser_next)
    else $error("serial next pointer wrong");

  pwr_next_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    rd_ack && up_lvl && addr_r == spx_pkg::OFS_PWR_HDR
      |-> o_cfg_rdata[31:16] == {pre.pwr_next, spx_pkg::EXT_CAP_VER})
    else $error("power next pointer or version wrong");

  // Once reads are open the serial dwords and subsystem codes must not move
  preload_hold_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    pre.ready |=> $stable(pre.ser_low) && $stable(pre.ser_high)
      && $stable(pre.maker_code) && $stable(pre.device_code))
    else $error("preloaded value changed after ready");
endmodule // spx_cfg_regs

// ### bench/spx_host_model.sv
`timescale 1ns/1ps
module spx_host_model (
  input  wire logic        i_mclk,
  input  wire logic        i_ack,
  input  wire logic [31:0] i_rdata,
  output logic             o_req,
  output logic             o_we,
  output logic [11:0]      o_addr,
  output logic [3:0]       o_be,
  output logic [31:0]      o_wdata
);
  // Idle bus at time zero
  initial begin
    o_req   = 1'b0;
    o_we    = 1'b0;
    o_addr  = 12'h000;
    o_be    = 4'h1;
    o_wdata = 32'h0;
  end

  // One dword request, held until the ack edge
  task automatic xfer(input logic we, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    rd = 32'h0;
    @(posedge i_mclk);
    o_req   <= 1'b1;
    o_we    <= we;
    o_addr  <= a;
    o_wdata <= wd;
    // Bounded wait, ready may still be pending
    for (n = 0; n < 64 && ok == 1'b0; n++) begin
      @(posedge i_mclk);
      if (i_ack === 1'b1) begin
        ok = 1'b1;
        rd = i_rdata;
      end
    end
    o_req   <= 1'b0;
    // Released lines change, so a stale value cannot pass
    o_addr  <= ~a;
    o_wdata <= ~wd;
  endtask
endmodule // spx_host_model

// ### bench/spx_cfg_regs_tb_top.sv
`timescale 1ns/1ps
module spx_cfg_regs_tb_top;
  logic        i_mclk, i_reset, up, dvld, dlvl;  // Clock, reset, strap, link
  logic        ld_we, ld_done;                   // Loader strobes
  logic [11:0] ld_addr;                          // Loader offset
  logic [31:0] ld_data;                          // Loader dword
  logic        req, we, ack, pref, rdy;          // Config handshake, outputs
  logic [11:0] addr;                             // Config offset
  logic [3:0]  be;                               // Byte enables
  logic [31:0] wdata, rdata;                     // Config data
  logic [1:0]  btype;                            // Window type output
  int          err_total, comparisons;           // Verdict counters
  // Preloaded upstream image: 98,9C,A0,A4,A8,E4,100,104,108,138,13C
  localparam logic [11:0] TA [11] = '{12'h098, 12'h09C, 12'h0A0, 12'h0A4, 12'h0A8,
    12'h0E4, 12'h100, 12'h104, 12'h108, 12'h138, 12'h13C};
  localparam logic [31:0] TE [11] = '{32'h0, 32'h0, 32'h0, 32'h0000_000D, 32'h5566_7788,
    32'h2, 32'hABC1_0003, 32'h1111_2222, 32'h3333_4444, 32'h1501_0004, 32'h0};

  spx_cfg_regs i_spx_cfg_regs (.i_mclk(i_mclk), .i_reset(i_reset), .i_port_up_pin(up),
    .i_deemph_vld(dvld), .i_deemph_lvl(dlvl), .i_ld_we(ld_we), .i_ld_addr(ld_addr),
    .i_ld_data(ld_data), .i_ld_done(ld_done), .i_cfg_req(req), .i_cfg_we(we),
    .i_cfg_addr(addr), .i_cfg_be(be), .i_cfg_wdata(wdata), .o_cfg_ack(ack),
    .o_cfg_rdata(rdata), .o_bwin_type(btype), .o_bwin_pref(pref), .o_ready(rdy));
  spx_host_model i_spx_host_model (.i_mclk(i_mclk), .i_ack(ack), .i_rdata(rdata),
    .o_req(req), .o_we(we), .o_addr(addr), .o_be(be), .o_wdata(wdata));

  // Free running 50 MHz clock
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  // Word comparison, counted
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Read one offset and compare, a lost ack also counts
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic        ok;
    i_spx_host_model.xfer(1'b0, a, 32'h0, d, ok);
    chk({31'h0, ok}, 32'h1);
    chk(d, exp);
  endtask

  // Write one offset, ack must come
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic [31:0] d;
    logic        ok;
    i_spx_host_model.xfer(1'b1, a, v, d, ok);
    chk({31'h0, ok}, 32'h1);
  endtask

  // Loader write, back to back allowed
  task automatic ld(input logic [11:0] a, input logic [31:0] v);
    @(posedge i_mclk);
    ld_we   <= 1'b1;
    ld_addr <= a;
    ld_data <= v;
  endtask

  // Reset with a chosen strap, optional preload, then wait for ready
  task automatic restart(input logic up_v, input logic pre);
    int n;
    @(posedge i_mclk);
    i_reset <= 1'b1;
    up      <= up_v;
    ld_done <= 1'b0;  // A stale done would lock the loader out
    repeat (6) @(posedge i_mclk);
    i_reset <= 1'b0;
    repeat (4) @(posedge i_mclk);
    if (pre) begin
      ld(12'h0A8, 32'h5566_7788);
      ld(12'h104, 32'h1111_2222);
      ld(12'h108, 32'h3333_4444);
      ld(12'h100, 32'hABC0_0000);  // Only the next pointer takes
      ld(12'h138, 32'h1500_0000);
    end
    @(posedge i_mclk);
    ld_we   <= 1'b0;
    ld_done <= 1'b1;
    for (n = 0; n < 20 && rdy !== 1'b1; n++) @(posedge i_mclk);
    chk({31'h0, rdy}, 32'h1);
  endtask

  // Downstream port: hidden registers, strap defaults
  task automatic t_down;
    restart(1'b0, 1'b0);
    rd(12'h098, 32'h0001_0000);
    rd(12'h0A8, {spx_pkg::SUBSYS_DEVICE_RST, spx_pkg::SUBSYS_MAKER_RST});
    rd(12'h100, 32'hFB41_0003);
    rd(12'h104, 32'h0);
    rd(12'h108, 32'h0);
    wr(12'h13C, 32'h1);
    wr(12'h0E4, 32'h7);
    foreach (TA[k]) if (TA[k] inside {12'h0E4, 12'h138, 12'h13C})
      rd(TA[k], 32'h0);
    rd(12'h140, 32'h0);
    chk({30'h0, btype}, 32'h0);
    $display("test down done");
  endtask

  // Upstream image after preload, then writes to read-only places
  task automatic t_up;
    restart(1'b1, 1'b1);
    ld(12'h104, 32'hDEAD_0000);  // Loader late, must be ignored
    @(posedge i_mclk);
    ld_we <= 1'b0;
    foreach (TA[k]) rd(TA[k], TE[k]);
    foreach (TA[k]) if (!(TA[k] inside {12'h0E4, 12'h13C})) wr(TA[k], 32'hFFFF_FFFF);
    foreach (TA[k]) rd(TA[k], TE[k]);
    $display("test up done");
  endtask

  // Budget entry per selector: base, type at 17:15, rail 010 at 20:18
  function automatic logic [31:0] pwr_exp(input logic [7:0] s);
    if (s == 8'h00) return 32'h000B_8004;
    if (s == 8'h01) return 32'h0009_8003;
    return 32'h0;
  endfunction

  // Selector sweep: two entries, then unsupported ones
  task automatic t_sel;
    logic [7:0] sv [4] = '{8'h01, 8'h00, 8'h02, 8'hFF};
    foreach (sv[k]) begin
      wr(12'h13C, {24'hFFFF_FF, sv[k]});
      rd(12'h13C, {24'h0, sv[k]});
      rd(12'h140, pwr_exp(sv[k]));
    end
    $display("test sel done");
  endtask

  // Window type and prefetch, four of the eight codes
  task automatic t_win;
    logic [2:0] wv [4] = '{3'h7, 3'h0, 3'h3, 3'h6};
    foreach (wv[k]) begin
      wr(12'h0E4, {29'h0, wv[k]});
      rd(12'h0E4, {29'h0, wv[k]});
      chk({29'h0, pref, btype}, {29'h0, wv[k]});
    end
    $display("test win done");
  endtask

  // Link reports both de-emphasis levels
  task automatic t_deemph;
    logic v;
    for (int k = 0; k < 2; k++) begin
      v = (k == 0);
      @(posedge i_mclk);
      dvld <= 1'b1;
      dlvl <= v;
      @(posedge i_mclk);
      dvld <= 1'b0;
      rd(12'h098, {15'h0, v, 16'h0});
    end
    $display("test deemph done");
  endtask

  // Counts, verdict, end of run
  task automatic summarize;
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Hang guard, far beyond the expected few hundred cycles
  initial begin
    #1_000_000;
    err_total++;
    summarize();
  end

  // Main sequence
  initial begin
    err_total = 0;
    comparisons = 0;
    i_reset = 1'b1;
    up = 1'b1;
    dvld = 1'b0;
    dlvl = 1'b0;
    ld_we = 1'b0;
    ld_done = 1'b0;
    ld_addr = 12'h000;
    ld_data = 32'h0;
    t_down();
    t_up();
    t_sel();
    t_win();
    t_deemph();
    summarize();
  end
endmodule // spx_cfg_regs_tb_top
